// file: rtl/pipe_pkg.sv
// Purpose: Constants and types for the four-phase fetch/execute pipeline.
// Assumes: 20 MHz core clock, one oscillator period per core clock.
// Notes:   Program memory depth is a plain default, not a part size.
package pipe_pkg;
	localparam int          PC_W        = 13;
	localparam int          INSN_W      = 14;
	localparam int          DATA_W      = 8;
	localparam int          FADDR_W     = 7;
	localparam int          STACK_DEPTH = 8;
	localparam int          SP_W        = 3;
	localparam int          INSN_COUNT  = 35;
	localparam int          PMEM_WORDS  = 2048;
	localparam logic [12:0] PMEM_MASK   = 13'h07FF;
	localparam logic [12:0] RESET_VEC   = 13'h0000;
	localparam logic [12:0] IRQ_VEC     = 13'h0004;
	localparam logic [13:0] NOP_WORD    = 14'h0000;
	localparam logic [1:0]  PH_ONE      = 2'h0;
	localparam logic [1:0]  PH_TWO      = 2'h1;
	localparam logic [1:0]  PH_THREE    = 2'h2;
	localparam logic [1:0]  PH_FOUR     = 2'h3;
	localparam int          PHASES      = 4;

	// Reduced set of operation classes the decoder separates
	typedef enum logic [2:0] {
		OP_NONE,
		OP_ALU,
		OP_JUMP,
		OP_CALL,
		OP_RETURN
	} op_class_t;
endpackage : pipe_pkg

// file: rtl/phase_gen.sv
// Purpose: Divides the core clock by four into one-hot phase enables.
// Assumes: Synchronous active-low reset.
// Notes:   Phases restart at phase_one after reset.
`timescale 1ns/1ps
module phase_gen
	import pipe_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	// Phase enables
	output logic [3:0]      phase_q
);
	logic [1:0] count_q;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			count_q <= PH_ONE;
		end else begin
			count_q <= count_q + 2'h1;
		end
	end

	// One-hot, so never two phases active at once
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			phase_q <= 4'h0;
		end else begin
			phase_q <= 4'h1 << (count_q);
		end
	end

	property p_one_hot;
		@(posedge core_clk) disable iff (!rst_n)
		$past(rst_n) |-> $onehot(phase_q);
	endproperty
	a_one_hot: assert property (p_one_hot) else $error("phases not one-hot");

	property p_order;
		@(posedge core_clk) disable iff (!rst_n)
		phase_q[0] |=> phase_q[1] ##1 phase_q[2] ##1 phase_q[3] ##1 phase_q[0];
	endproperty
	a_order: assert property (p_order) else $error("phase order broken");
endmodule : phase_gen

// file: rtl/fetch_exec_core.sv
// Purpose: Two-stage fetch/execute sequencer with four-phase timing.
// Assumes: Program memory answers combinationally on pmem_data; data file likewise.
// Notes:   Operation semantics beyond control flow are left to the data path.
`timescale 1ns/1ps
module fetch_exec_core
	import pipe_pkg::*;
(
	// Clock and reset
	input  wire logic                core_clk,
	input  wire logic                rst_n,
	// Program memory
	output logic [PC_W-1:0]          pmem_addr,
	input  wire logic [INSN_W-1:0]   pmem_data,
	// Data memory
	output logic [FADDR_W-1:0]       dmem_addr,
	output logic                     dmem_rd,
	input  wire logic [DATA_W-1:0]   dmem_rdata,
	output logic                     dmem_wr,
	output logic [DATA_W-1:0]        dmem_wdata,
	// Interrupt request from outside core
	input  wire logic                irq_req,
	// Status
	output logic [3:0]               phase,
	output logic                     retire,
	output logic                     illegal
);
	logic [3:0]         ph;
	logic [PC_W-1:0]    pc_q;
	logic [INSN_W-1:0]  exec_q;
	logic               exec_vld_q;
	logic [DATA_W-1:0]  operand_q;
	logic [PC_W-1:0]    stack_q [STACK_DEPTH];
	logic [SP_W-1:0]    sp_q;
	logic [1:0]         irq_sync_q;
	logic               irq_pend_q;
	logic [PC_W-1:0]    target;
	logic               redirect;
	op_class_t          cls;

	phase_gen u_phase (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.phase_q  (ph)
	);

	// Decoder for control-flow classes; every other word decodes as OP_ALU
	function automatic op_class_t decode(input logic [INSN_W-1:0] w);
		op_class_t c;
		c = OP_ALU;
		case (w[13:11])
			3'h4:    c = OP_CALL;
			3'h5:    c = OP_JUMP;
			default: c = OP_ALU;
		endcase
		if (w == 14'h0008) c = OP_RETURN;
		return c;
	endfunction : decode

	function automatic logic legal(input logic [INSN_W-1:0] w);
		return !(w[13:12] == 2'h0 && w[11:8] == 4'h0 && w[7] == 1'b0 &&
			w[6:0] != 7'h00 && w[6:0] != 7'h08 && w[6:0] != 7'h09 &&
			w[6:0] != 7'h62 && w[6:0] != 7'h63 && w[6:0] != 7'h64 &&
			w[6:5] == 2'h0 && w[4:0] != 5'h00);
	endfunction : legal

	always_comb begin
		cls      = exec_vld_q ? decode(exec_q) : OP_NONE;
		redirect = 1'b0;
		target   = pc_q;
		case (cls)
			OP_JUMP, OP_CALL: begin
				redirect = 1'b1;
				target   = {2'h0, exec_q[10:0]} & PMEM_MASK;
			end
			OP_RETURN: begin
				redirect = 1'b1;
				target   = stack_q[sp_q - SP_W'(1)];
			end
			default: begin
				redirect = 1'b0;
				target   = pc_q;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irq_sync_q <= 2'h0;
		end else begin
			irq_sync_q <= {irq_sync_q[0], irq_req};
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irq_pend_q <= 1'b0;
		end else if (irq_sync_q[1]) begin
			irq_pend_q <= 1'b1;
		end else if (ph[3] && !redirect) begin
			irq_pend_q <= 1'b0;
		end
	end

	// Program counter: increments on phase_one, redirect at phase_four
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pc_q <= RESET_VEC;
		end else if (ph[3] && redirect) begin
			pc_q <= target;
		end else if (ph[3] && irq_pend_q) begin
			pc_q <= IRQ_VEC;
		end else if (ph[0]) begin
			pc_q <= (pc_q + 13'h0001) & PMEM_MASK;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pmem_addr <= RESET_VEC;
		end else if (ph[0]) begin
			pmem_addr <= pc_q & PMEM_MASK;
		end
	end

	// Instruction register captured at phase_four, executed next cycle
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			exec_q     <= NOP_WORD;
			exec_vld_q <= 1'b0;
		end else if (ph[3]) begin
			exec_q     <= pmem_data;
			exec_vld_q <= !(redirect || irq_pend_q);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sp_q <= '0;
		end else if (ph[3] && cls == OP_CALL) begin
			stack_q[sp_q] <= pmem_addr;
			sp_q          <= sp_q + SP_W'(1);
		end else if (ph[3] && cls == OP_RETURN) begin
			sp_q <= sp_q - SP_W'(1);
		end
	end

	// Data memory: read on phase_two, write on phase_four
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			dmem_addr  <= '0;
			dmem_rd    <= 1'b0;
			dmem_wr    <= 1'b0;
			dmem_wdata <= '0;
			operand_q  <= '0;
		end else begin
			dmem_addr <= exec_q[FADDR_W-1:0];
			dmem_rd   <= ph[0] && cls == OP_ALU;
			dmem_wr   <= ph[2] && cls == OP_ALU && exec_q[7];
			if (dmem_rd) begin
				operand_q <= dmem_rdata;
			end
			if (ph[2]) begin
				dmem_wdata <= operand_q;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			phase   <= 4'h0;
			retire  <= 1'b0;
			illegal <= 1'b0;
		end else begin
			// Next enable, so status lines up with the strobes
			phase   <= (ph == 4'h0) ? 4'h1 : {ph[2:0], ph[3]};
			retire  <= ph[3] && exec_vld_q;
			illegal <= ph[3] && exec_vld_q && !legal(exec_q);
		end
	end

	property p_read_phase;
		@(posedge core_clk) disable iff (!rst_n)
		dmem_rd |-> phase[1];
	endproperty
	a_read_phase: assert property (p_read_phase) else $error("read outside phase two");

	property p_write_phase;
		@(posedge core_clk) disable iff (!rst_n)
		dmem_wr |-> phase[3];
	endproperty
	a_write_phase: assert property (p_write_phase) else $error("write outside phase four");

	property p_pc_step;
		@(posedge core_clk) disable iff (!rst_n)
		ph[0] |=> pc_q == (($past(pc_q) + 13'h0001) & PMEM_MASK);
	endproperty
	a_pc_step: assert property (p_pc_step) else $error("pc did not step");

	property p_flush;
		@(posedge core_clk) disable iff (!rst_n)
		ph[3] && redirect |=> !exec_vld_q [*4];
	endproperty
	a_flush: assert property (p_flush) else $error("branch shadow executed");

	property p_retire_rate;
		@(posedge core_clk) disable iff (!rst_n)
		retire |=> !retire [*3];
	endproperty
	a_retire_rate: assert property (p_retire_rate) else $error("retire too often");

	property p_wrap;
		@(posedge core_clk) disable iff (!rst_n)
		(pc_q & ~PMEM_MASK) == 13'h0000;
	endproperty
	a_wrap: assert property (p_wrap) else $error("pc beyond memory");

	property p_first_exec;
		@(posedge core_clk)
		!rst_n |=> !exec_vld_q [*4];
	endproperty
	a_first_exec: assert property (p_first_exec) else $error("early execute");

	property p_capture;
		@(posedge core_clk) disable iff (!rst_n)
		ph[3] |=> exec_q == $past(pmem_data);
	endproperty
	a_capture: assert property (p_capture) else $error("fetch not captured");
endmodule : fetch_exec_core

// file: sim/prog_data_model.sv
// Purpose: Program memory and data file facing the fetch/execute core.
// Assumes: Both arrays answer combinationally.
// Notes:   Idle data bus shows the inverse of the last read value.
`timescale 1ns/1ps
module prog_data_model
	import pipe_pkg::*;
(
	// Clock
	input  wire logic               core_clk,
	// Program memory
	input  wire logic [PC_W-1:0]    pmem_addr,
	output logic [INSN_W-1:0]       pmem_data,
	// Data memory
	input  wire logic [FADDR_W-1:0] dmem_addr,
	input  wire logic               dmem_rd,
	output logic [DATA_W-1:0]       dmem_rdata,
	input  wire logic               dmem_wr,
	input  wire logic [DATA_W-1:0]  dmem_wdata
);
	logic [INSN_W-1:0] rom [PMEM_WORDS];
	logic [DATA_W-1:0] ram [128];
	logic              wr_seen [128];
	logic [DATA_W-1:0] last_q;

	initial begin
		last_q = 8'h5A;
		for (int i = 0; i < 128; i++) begin
			ram[i] = 8'(i);
			wr_seen[i] = 1'b0;
		end
	end

	assign pmem_data  = rom[pmem_addr & PMEM_MASK];
	assign dmem_rdata = dmem_rd ? ram[dmem_addr] : ~last_q;

	always @(posedge core_clk) begin
		if (dmem_rd)
			last_q <= ram[dmem_addr];
		if (dmem_wr) begin
			ram[dmem_addr] <= dmem_wdata;
			wr_seen[dmem_addr] <= 1'b1;
		end
	end
endmodule : prog_data_model

// file: sim/fetch_exec_core_tb_top.sv
// Purpose: Self-checking bench for the fetch/execute sequencer.
// Assumes: Program and data arrays held by the partner model.
// Notes:   Program runs straight code, a jump, a call/return and an interrupt.
`timescale 1ns/1ps
module fetch_exec_core_tb_top;
	import pipe_pkg::*;
	logic                core_clk, rst_n, irq_req;
	logic [PC_W-1:0]     pmem_addr;
	logic [INSN_W-1:0]   pmem_data;
	logic [FADDR_W-1:0]  dmem_addr;
	logic                dmem_rd, dmem_wr, retire, illegal;
	logic [DATA_W-1:0]   dmem_rdata, dmem_wdata;
	logic [3:0]          phase;
	int                  bad_count, compares, cycles, last_ret, gap, gap4, gap8, ill_count;

	fetch_exec_core dut (.core_clk(core_clk), .rst_n(rst_n), .pmem_addr(pmem_addr),
		.pmem_data(pmem_data), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
		.dmem_rdata(dmem_rdata), .dmem_wr(dmem_wr), .dmem_wdata(dmem_wdata),
		.irq_req(irq_req), .phase(phase), .retire(retire), .illegal(illegal));
	prog_data_model mdl (.core_clk(core_clk), .pmem_addr(pmem_addr),
		.pmem_data(pmem_data), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
		.dmem_rdata(dmem_rdata), .dmem_wr(dmem_wr), .dmem_wdata(dmem_wdata));

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic summarize();
		if (bad_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			summarize();
		end
	end

	// Strobe phases and spacing of completions
	always @(negedge core_clk) begin
		if (rst_n === 1'b1 && dmem_rd === 1'b1) chk(16'(phase), 16'h2);
		if (rst_n === 1'b1 && dmem_wr === 1'b1) chk(16'(phase), 16'h8);
		if (rst_n === 1'b1 && illegal === 1'b1) ill_count++;
		if (rst_n === 1'b1 && retire === 1'b1) begin
			gap = cycles - last_ret;
			if (last_ret > 0) chk(16'(gap >= 4), 16'h1);
			if (gap == 4) gap4 = 1;
			if (gap == 8) gap8 = 1;
			last_ret = cycles;
		end
	end

	task automatic t_reset();
		repeat (5) @(negedge core_clk);
		chk(16'(pmem_addr), 16'h0);
		chk(16'(phase), 16'h0);
		chk(16'(retire), 16'h0);
		rst_n = 1'b1;
		for (int i = 1; i <= 9; i++) begin
			@(negedge core_clk);
			if (i <= 4) chk(16'(phase), 16'(1 << (i - 1)));
			chk(16'(retire), 16'(i == 9));
		end
	endtask : t_reset

	task automatic t_flow();
		repeat (90) @(negedge core_clk);
		chk(16'(mdl.wr_seen[5]), 16'h1);
		chk(16'(mdl.wr_seen[6]), 16'h0);
		chk(16'(mdl.wr_seen[7]), 16'h1);
		chk(16'(mdl.wr_seen[8]), 16'h1);
		chk(16'(mdl.wr_seen[9]), 16'h0);
		chk(16'(gap4), 16'h1);
		chk(16'(gap8), 16'h1);
		chk(16'(ill_count), 16'h0);
	endtask : t_flow

	task automatic t_irq();
		int hit;
		hit = 0;
		irq_req = 1'b1;
		for (int i = 0; i < 64 && hit == 0; i++) begin
			@(negedge core_clk);
			if (pmem_addr === IRQ_VEC) hit = 1;
		end
		irq_req = 1'b0;
		chk(16'(hit), 16'h1);
		repeat (40) @(negedge core_clk);
		chk(16'(mdl.wr_seen[10]), 16'h1);
		chk(16'(ill_count), 16'h1);
	endtask : t_irq

	initial begin
		rst_n = 1'b0;
		irq_req = 1'b0;
		bad_count = 0;
		compares = 0;
		cycles = 0;
		last_ret = 0;
		gap4 = 0;
		gap8 = 0;
		ill_count = 0;
		for (int i = 0; i < PMEM_WORDS; i++) mdl.rom[i] = NOP_WORD;
		// Writes carry bit7; 101 jump, 100 call, 0008h return
		mdl.rom[0]  = 14'h0085;
		mdl.rom[1]  = 14'h2810;
		mdl.rom[2]  = 14'h0086;
		mdl.rom[4]  = 14'h008A;
		// Word outside the reduced set, run once after the interrupt entry
		mdl.rom[5]  = 14'h0001;
		mdl.rom[6]  = 14'h2813;
		mdl.rom[16] = 14'h0087;
		mdl.rom[17] = 14'h2020;
		mdl.rom[18] = 14'h0088;
		mdl.rom[19] = 14'h2813;
		mdl.rom[32] = 14'h0008;
		mdl.rom[33] = 14'h0089;
		t_reset();
		t_flow();
		t_irq();
		summarize();
	end
endmodule : fetch_exec_core_tb_top
